//--- design/hall_commut_cfg.svh
// constants for the hall commutation predriver: timing counts and code values
// assumes a 200 MHz system clock
`ifndef HALL_COMMUT_CFG_SVH
`define HALL_COMMUT_CFG_SVH
`define CLK_PERIOD_NS      5
`define PWM_CARRIER_BITS   8
`define PWM_FULL_DUTY      8'hff
`define CTL_ZERO_MV        1350
`define CTL_FULL_MV        3000
`define CTL_MV_BITS        12
`define ILIM_MV            250
`define POR_CARRIERS       4
`define LOCK_ON_CARRIERS   2000
`define LOCK_OFF_CARRIERS  30000
`define LOCK_TMR_BITS      16
`endif

//--- design/hall_commut_pkg.sv
// types for the hall commutation predriver
// assumes hall_commut_cfg.svh is compiled alongside
package hall_commut_pkg;
  typedef enum logic [3:0] {
    LOCK_POR  = 4'h1,
    LOCK_RUN  = 4'h2,
    LOCK_ON   = 4'h4,
    LOCK_OFF  = 4'h8
  } lock_state_t;
endpackage : hall_commut_pkg

//--- design/hall_commut.sv
// hall commutation predriver: hall decode, pwm gating, lock protection
// assumes all inputs synchronous to i_sys_clk; analog thresholds given as digital flags/values
`timescale 1ns/10ps
`default_nettype none
`include "hall_commut_cfg.svh"
module hall_commut
  import hall_commut_pkg::*;
#(
  parameter int unsigned CARRIER_BITS = `PWM_CARRIER_BITS,
  parameter int unsigned LOCK_ON_CNT  = `LOCK_ON_CARRIERS,
  parameter int unsigned LOCK_OFF_CNT = `LOCK_OFF_CARRIERS,
  parameter int unsigned POR_CNT      = `POR_CARRIERS
) (
  input  wire logic                   i_sys_clk,
  input  wire logic                   i_rst,
  input  wire logic [2:0]             i_hall_phase_pos,
  input  wire logic [2:0]             i_hall_phase_neg,
  input  wire logic                   i_reverse,
  input  wire logic                   i_pulse_duty_input,
  input  wire logic                   i_hall_output_select,
  input  wire logic [`CTL_MV_BITS-1:0] i_control_voltage_mv,
  input  wire logic [`CTL_MV_BITS-1:0] i_current_sense_mv,
  input  wire logic                   i_control_supply_low,
  input  wire logic                   i_lock_timing_grounded,
  output logic                        o_phase_a_high_drive,
  output logic                        o_phase_b_high_drive,
  output logic                        o_phase_c_high_drive,
  output logic                        o_phase_a_low_drive,
  output logic                        o_phase_b_low_drive,
  output logic                        o_phase_c_low_drive,
  output logic                        o_hall_pulse_output,
  output logic                        o_hall_pulse_output_oe,
  output logic                        o_lock_status_n,
  output logic                        o_lock_status_oe
);

  // refuse parameter values that the counters cannot serve
  generate
    if (CARRIER_BITS != `PWM_CARRIER_BITS || LOCK_ON_CNT == 0 || LOCK_OFF_CNT == 0
        || LOCK_ON_CNT >= (1 << `LOCK_TMR_BITS) || LOCK_OFF_CNT >= (1 << `LOCK_TMR_BITS)
        || POR_CNT == 0 || POR_CNT >= (1 << `LOCK_TMR_BITS))
    begin : g_bad_param
      $error("hall_commut: unsupported parameter values");
    end
  endgenerate

  // last timer count of each timed phase
  localparam logic [`LOCK_TMR_BITS-1:0] ON_LAST  = `LOCK_TMR_BITS'(LOCK_ON_CNT - 1);
  localparam logic [`LOCK_TMR_BITS-1:0] OFF_LAST = `LOCK_TMR_BITS'(LOCK_OFF_CNT - 1);
  localparam logic [`LOCK_TMR_BITS-1:0] POR_LAST = `LOCK_TMR_BITS'(POR_CNT - 1);
  localparam logic [`LOCK_TMR_BITS-1:0] RUN_LAST = `LOCK_TMR_BITS'(LOCK_ON_CNT - 1);

  // map hall pattern (phase1,phase2,phase3) to {hi_a,hi_b,hi_c,lo_a,lo_b,lo_c}
  function automatic logic [5:0] commut_sel(input logic [2:0] h);
    case (h)
      3'b101:  commut_sel = 6'b010_100;
      3'b100:  commut_sel = 6'b001_100;
      3'b110:  commut_sel = 6'b001_010;
      3'b010:  commut_sel = 6'b100_010;
      3'b011:  commut_sel = 6'b100_001;
      3'b001:  commut_sel = 6'b010_001;
      default: commut_sel = 6'b000_000;
    endcase
  endfunction : commut_sel

  // last timer count of the phase the lock machine is in
  function automatic logic [`LOCK_TMR_BITS-1:0] phase_last(input lock_state_t st);
    case (st)
      LOCK_OFF: phase_last = OFF_LAST;
      LOCK_ON:  phase_last = ON_LAST;
      LOCK_POR: phase_last = POR_LAST;
      default:  phase_last = RUN_LAST;
    endcase
  endfunction : phase_last

  // hall comparators, bit 2 is phase1
  logic [2:0] hall_lvl;
  logic [2:0] hall_fwd;
  logic [5:0] sel;
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_cmp
      assign hall_lvl[2-gi] = i_hall_phase_pos[gi] > i_hall_phase_neg[gi];
    end
  endgenerate
  assign hall_fwd = i_reverse ? ~hall_lvl : hall_lvl;
  assign sel      = commut_sel(hall_fwd);

  // pwm carrier and duty compare state
  logic [CARRIER_BITS-1:0] carrier_q, carrier_d;
  logic [CARRIER_BITS-1:0] duty_q, duty_d;
  logic                    carrier_wrap;
  logic [`CTL_MV_BITS:0]   ctl_span;

  // carrier step and control voltage to duty compare value
  always_comb
  begin
    carrier_d    = carrier_q + 1'b1;
    carrier_wrap = &carrier_q;
    ctl_span     = '0;
    if (i_control_voltage_mv <= `CTL_MV_BITS'(`CTL_ZERO_MV))
      duty_d = '0;
    else if (i_control_voltage_mv >= `CTL_MV_BITS'(`CTL_FULL_MV))
      duty_d = `PWM_FULL_DUTY;
    else
    begin
      ctl_span = {1'b0, i_control_voltage_mv} - (`CTL_MV_BITS+1)'(`CTL_ZERO_MV);
      duty_d   = CARRIER_BITS'((32'(ctl_span) * 255) / (`CTL_FULL_MV - `CTL_ZERO_MV));
    end
  end

  // carrier registers
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      carrier_q <= '0;
      duty_q    <= '0;
    end
    else
    begin
      carrier_q <= carrier_d;
      duty_q    <= duty_d;
    end
  end

  // full duty keeps the compare on through the whole carrier
  logic pwm_on;
  assign pwm_on = (duty_q == `PWM_FULL_DUTY) || (carrier_q < duty_q);

  // lock protection state
  lock_state_t               lock_st_q, lock_st_d;
  logic [`LOCK_TMR_BITS-1:0] lock_tmr_q, lock_tmr_d;
  logic [2:0]                hall_prev_q, hall_prev_d;
  logic                      hall_rise;
  logic                      locked_q, locked_d;

  // one discharge pulse per hall period: rising edge of phase1
  assign hall_rise = hall_lvl[2] & ~hall_prev_q[2];

  // power-up hold, run watch and locked on/off alternation
  always_comb
  begin
    lock_st_d   = lock_st_q;
    lock_tmr_d  = lock_tmr_q;
    hall_prev_d = hall_lvl;
    locked_d    = locked_q;
    case (lock_st_q)
      LOCK_POR:
      begin
        if (carrier_wrap)
        begin
          if (lock_tmr_q == POR_LAST)
          begin
            lock_st_d  = LOCK_RUN;
            lock_tmr_d = '0;
          end
          else
            lock_tmr_d = lock_tmr_q + 1'b1;
        end
      end
      LOCK_RUN:
      begin
        if (hall_rise || i_lock_timing_grounded)
          lock_tmr_d = '0;
        else if (carrier_wrap)
        begin
          if (lock_tmr_q == RUN_LAST)
          begin
            lock_st_d  = LOCK_OFF;
            lock_tmr_d = '0;
            locked_d   = 1'b1;
          end
          else
            lock_tmr_d = lock_tmr_q + 1'b1;
        end
      end
      LOCK_OFF, LOCK_ON:
      begin
        if (hall_rise || i_lock_timing_grounded)
        begin
          lock_st_d  = LOCK_RUN;
          lock_tmr_d = '0;
          locked_d   = 1'b0;
        end
        else if (carrier_wrap)
        begin
          if (lock_tmr_q == phase_last(lock_st_q))
          begin
            lock_st_d  = (lock_st_q == LOCK_OFF) ? LOCK_ON : LOCK_OFF;
            lock_tmr_d = '0;
          end
          else
            lock_tmr_d = lock_tmr_q + 1'b1;
        end
      end
      default:
      begin
        lock_st_d  = LOCK_POR;
        lock_tmr_d = '0;
      end
    endcase
  end

  // lock protection registers
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      lock_st_q   <= LOCK_POR;
      lock_tmr_q  <= '0;
      hall_prev_q <= '0;
      locked_q    <= 1'b0;
    end
    else
    begin
      lock_st_q   <= lock_st_d;
      lock_tmr_q  <= lock_tmr_d;
      hall_prev_q <= hall_prev_d;
      locked_q    <= locked_d;
    end
  end

  // output drive next values
  logic       lock_drive_ok;
  logic       ilim;
  logic       hi_gate;
  logic [5:0] drv_q, drv_d;
  logic       hp_q, hp_d;
  logic       hp_oe_q, hp_oe_d;
  logic       rd_q, rd_d;

  assign lock_drive_ok = (lock_st_q == LOCK_RUN) || (lock_st_q == LOCK_ON);
  assign ilim          = i_current_sense_mv > `CTL_MV_BITS'(`ILIM_MV);
  assign hi_gate = pwm_on & ~i_pulse_duty_input & ~ilim & ~i_control_supply_low
                   & lock_drive_ok;

  // gate the high side of the selected pair and pick the hall pulse source
  always_comb
  begin
    drv_d = {sel[5:3] & {3{hi_gate}}, sel[2:0]};
    if (lock_st_q == LOCK_POR)
      drv_d = '0;
    // synthesized: xor of all three halls, single: phase1
    hp_d = i_hall_output_select ? ^hall_lvl : hall_lvl[2];
    hp_oe_d = ~hp_d; // a low level pulls the pin
    rd_d = ~locked_d;
  end

  // output registers
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      drv_q <= '0;
      hp_q  <= 1'b0;
      hp_oe_q <= 1'b1;
      rd_q  <= 1'b0;
    end
    else
    begin
      drv_q <= drv_d;
      hp_q  <= hp_d;
      hp_oe_q <= hp_oe_d;
      rd_q  <= rd_d;
    end
  end

  // drives come straight from their registers
  assign o_phase_a_high_drive   = drv_q[5];
  assign o_phase_b_high_drive   = drv_q[4];
  assign o_phase_c_high_drive   = drv_q[3];
  assign o_phase_a_low_drive    = drv_q[2];
  assign o_phase_b_low_drive    = drv_q[1];
  assign o_phase_c_low_drive    = drv_q[0];
  // open-collector style: pin pulled low when output level is low
  assign o_hall_pulse_output    = hp_q;
  assign o_hall_pulse_output_oe = hp_oe_q;
  assign o_lock_status_n        = 1'b0;
  assign o_lock_status_oe       = rd_q;

endmodule : hall_commut
`default_nettype wire

//--- tb/hall_exp_pkg.sv
// expected drive pairs for the bench side
// assumes bit0 of a hall pattern is phase1
package hall_exp_pkg;
  // {high c,b,a, low c,b,a}, equal halls give all off
  function automatic logic [5:0] dec(input logic [2:0] h, input logic r);
    logic [2:0] p;
    p = r ? ~h : h;
    case (p)
      3'h5: dec = 6'h11;
      3'h1: dec = 6'h21;
      3'h3: dec = 6'h22;
      3'h2: dec = 6'h0a;
      3'h6: dec = 6'h0c;
      3'h4: dec = 6'h14;
      default: dec = 6'h00;
    endcase
  endfunction : dec
endpackage : hall_exp_pkg

//--- tb/hall_sensor_model.sv
// hall sensor model: differential comparator sides of each phase
// assumes the bench sets the magnetic pattern, bit0 = phase1
`timescale 1ns/10ps
`default_nettype none
module hall_sensor_model (
  input  wire logic [2:0] i_pattern,
  output logic      [2:0] o_pos,
  output logic      [2:0] o_neg
);
  // a high phase shows plus above minus, a low phase the reverse
  assign o_pos = i_pattern;
  assign o_neg = ~i_pattern;
endmodule : hall_sensor_model
`default_nettype wire

//--- tb/hall_commut_sva.sv
// port checker for the hall commutation predriver
// assumes binding into hall_commut, sees its ports only
`timescale 1ns/10ps
`default_nettype none
module hall_commut_sva
  import hall_exp_pkg::*;
(
  input wire logic        i_sys_clk,
  input wire logic        i_rst,
  input wire logic [2:0]  i_hall_phase_pos,
  input wire logic [2:0]  i_hall_phase_neg,
  input wire logic        i_reverse,
  input wire logic        i_pulse_duty_input,
  input wire logic        i_hall_output_select,
  input wire logic [11:0] i_control_voltage_mv,
  input wire logic [11:0] i_current_sense_mv,
  input wire logic        i_control_supply_low,
  input wire logic        i_lock_timing_grounded,
  input wire logic        o_phase_a_high_drive,
  input wire logic        o_phase_b_high_drive,
  input wire logic        o_phase_c_high_drive,
  input wire logic        o_phase_a_low_drive,
  input wire logic        o_phase_b_low_drive,
  input wire logic        o_phase_c_low_drive,
  input wire logic        o_hall_pulse_output,
  input wire logic        o_hall_pulse_output_oe,
  input wire logic        o_lock_status_oe
);
  logic [2:0] h, hi, lo;
  logic [5:0] e_q;
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);
  // decoded halls and grouped drives
  assign h  = i_hall_phase_pos & ~i_hall_phase_neg;
  assign hi = {o_phase_c_high_drive, o_phase_b_high_drive, o_phase_a_high_drive};
  assign lo = {o_phase_c_low_drive, o_phase_b_low_drive, o_phase_a_low_drive};
  // pair allowed by last cycle's halls
  always_ff @(posedge i_sys_clk or posedge i_rst)
    if (i_rst)
      e_q <= 6'h00;
    else
      e_q <= dec(h, i_reverse);
  a_halls_equal_off: assert property ((h == 3'h0 || h == 3'h7) |=> {hi, lo} == 6'h00)
    else $error("drives on with equal halls");
  a_high_decode: assert property ((hi & ~e_q[5:3]) == 3'h0)
    else $error("wrong high drive");
  a_low_decode: assert property ((lo & ~e_q[2:0]) == 3'h0)
    else $error("wrong low drive");
  a_pulse_high_off: assert property (i_pulse_duty_input |=> hi == 3'h0)
    else $error("high drive with pulse input high");
  a_supply_low_off: assert property (i_control_supply_low |=> hi == 3'h0)
    else $error("high drive in undervoltage");
  a_limit_cuts_high: assert property ((i_current_sense_mv > 12'h0fa) |=> hi == 3'h0)
    else $error("high drive over current limit");
  a_zero_duty_off: assert property ((i_control_voltage_mv <= 12'h546)[*2] |=> hi == 3'h0)
    else $error("high drive at zero duty");
  a_pulse_pin_src: assert property (!i_rst |=> o_hall_pulse_output_oe ==
    !($past(i_hall_output_select) ? ^$past(h) : $past(h[0])))
    else $error("wrong hall pulse source");
  a_pulse_pin_pair: assert property (o_hall_pulse_output != o_hall_pulse_output_oe)
    else $error("hall pulse level and enable disagree");
  a_lock_grounded_on: assert property ((!i_rst && i_lock_timing_grounded) |=> o_lock_status_oe)
    else $error("lock status off with protection disabled");
  c_lock_drive_on: cover property (!o_lock_status_oe && hi != 3'h0);
  c_high_on: cover property (hi != 3'h0);
  c_reverse_on: cover property (i_reverse && hi != 3'h0);
  c_pulse_sel: cover property (i_hall_output_select && lo != 3'h0);
endmodule : hall_commut_sva
bind hall_commut hall_commut_sva u_sva (.*);
`default_nettype wire

//--- tb/hall_commut_tb.sv
// self-checking bench for the hall commutation predriver
// assumes the package, hall model and checker are compiled first
`timescale 1ns/10ps
`default_nettype none
module hall_commut_tb
  import hall_exp_pkg::*;
;
  logic        clk = 1'b0, rst = 1'b1, rev = 1'b0, pwi = 1'b0;
  logic        sel = 1'b0, uv = 1'b0, gnd = 1'b1;
  logic [2:0]  pat = 3'h5;
  logic [11:0] cv = 12'hbb8, rf = 12'h000;
  wire  [2:0]  hpos, hneg;
  wire  [5:0]  drv;
  wire         hp_o, hp_oe, lk_n, lk_oe;
  int          fails = 0, total_checks = 0, n;
  hall_sensor_model u_hall (.i_pattern(pat), .o_pos(hpos), .o_neg(hneg));
  hall_commut #(.LOCK_ON_CNT(3), .LOCK_OFF_CNT(5), .POR_CNT(1)) dut (
    .i_sys_clk(clk), .i_rst(rst), .i_hall_phase_pos(hpos), .i_hall_phase_neg(hneg),
    .i_reverse(rev), .i_pulse_duty_input(pwi), .i_hall_output_select(sel),
    .i_control_voltage_mv(cv), .i_current_sense_mv(rf), .i_control_supply_low(uv),
    .i_lock_timing_grounded(gnd), .o_phase_a_high_drive(drv[3]),
    .o_phase_b_high_drive(drv[4]), .o_phase_c_high_drive(drv[5]),
    .o_phase_a_low_drive(drv[0]), .o_phase_b_low_drive(drv[1]),
    .o_phase_c_low_drive(drv[2]), .o_hall_pulse_output(hp_o),
    .o_hall_pulse_output_oe(hp_oe), .o_lock_status_n(lk_n), .o_lock_status_oe(lk_oe));
  // 200 MHz clock
  initial
    forever #2.5 clk = ~clk;
  task automatic chk_drv(input logic [5:0] got, input logic [5:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_drv
  task automatic chk_bit(input logic got, input logic exp);
    chk_drv({5'h00, got}, {5'h00, exp});
  endtask : chk_bit
  task automatic step(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask : step
  task automatic apply(input logic [2:0] p, input logic r);
    @(posedge clk);
    pat <= p;
    rev <= r;
    step(3);
  endtask : apply
  task automatic end_sim;
    $display("checks=%0d fails=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_sim
  // main sequence
  initial
  begin
    void'($urandom(32'h7cd1445b));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    step(300);
    for (int i = 0; i < 16; i++)
    begin
      apply(i[2:0], i[3]);
      chk_drv(drv, dec(i[2:0], i[3]));
    end
    $display("decode test done");
    apply(3'h5, 1'b0);
    for (int k = 0; k < 6; k++)
    begin
      @(posedge clk);
      pwi <= (k == 0);
      uv  <= (k == 1);
      rf  <= (k == 2) ? 12'h0fb : (k == 3) ? 12'h0fa : 12'h000;
      cv  <= (k == 4) ? 12'h546 : 12'hbb8;
      step(3);
      chk_drv(drv, (k == 3 || k == 5) ? 6'h11 : 6'h01);
    end
    @(posedge clk);
    cv <= 12'h87f;
    step(3);
    n = 0;
    repeat (256)
    begin
      step(1);
      n += (drv[5:3] != 3'h0);
    end
    chk_bit(n >= 124 && n <= 132, 1'b1);
    @(posedge clk);
    cv <= 12'hbb8;
    $display("gate test done");
    for (int j = 0; j < 40; j++)
    begin
      @(posedge clk);
      pat <= 3'($urandom);
      rev <= 1'($urandom);
      pwi <= ($urandom % 4) == 0;
      uv  <= ($urandom % 4) == 0;
      sel <= 1'($urandom);
      rf  <= 12'($urandom % 300);
      step(3);
      chk_drv(drv, dec(pat, rev) & {{3{!pwi && !uv && rf <= 12'h0fa}}, 3'h7});
      chk_bit(hp_oe, !(sel ? ^pat : pat[0]));
      chk_bit(hp_o, sel ? ^pat : pat[0]);
    end
    $display("random test done");
    @(posedge clk);
    {pwi, uv, rev, gnd} <= 4'h0;
    rf  <= 12'h000;
    pat <= 3'h5;
    step(3);
    chk_bit(lk_oe, 1'b1);
    n = 0;
    while (lk_oe !== 1'b0 && n < 2000)
    begin
      step(1);
      n++;
    end
    chk_bit(lk_oe, 1'b0);
    step(10);
    chk_drv(drv, 6'h01);
    n = 0;
    while (drv[5:3] === 3'h0 && n < 2000)
    begin
      step(1);
      n++;
    end
    chk_drv(drv, 6'h11);
    chk_bit(lk_oe, 1'b0);
    chk_bit(lk_n, 1'b0);
    apply(3'h2, 1'b0);
    apply(3'h3, 1'b0);
    step(2);
    chk_bit(lk_oe, 1'b1);
    chk_drv(drv, 6'h22);
    $display("lock test done");
    end_sim();
  end
  // watchdog against a hang
  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    end_sim();
  end
endmodule : hall_commut_tb
`default_nettype wire
